// >>> design/fcm_pkg.sv
// Shared constants for the floating-point conditional move unit.
// Assumes a 32-bit instruction word and an APB register slave with 32-bit data.
package fcm_pkg;

  // Instruction word fields
  localparam int OP_HI = 31;
  localparam int OP_LO = 30;
  localparam int RD_HI = 29;
  localparam int RD_LO = 25;
  localparam int MAJOR_HI = 24;
  localparam int MAJOR_LO = 19;
  localparam int COND_HI = 17;
  localparam int COND_LO = 14;
  localparam int SEL_HI = 13;
  localparam int SEL_LO = 11;
  localparam int SUB_HI = 10;
  localparam int SUB_LO = 5;
  localparam int SRC_HI = 4;
  localparam int SRC_LO = 0;

  // Encodings
  localparam logic [1:0] FMT_ARITH = 2'h2;
  localparam logic [5:0] MAJOR_OPCODE_FCM = 6'h35;
  localparam logic [5:0] SUB_SINGLE = 6'h01;
  localparam logic [5:0] SUB_DOUBLE = 6'h02;
  localparam logic [5:0] SUB_QUAD = 6'h03;
  localparam logic [2:0] SEL_INT32 = 3'h4;
  localparam logic [2:0] SEL_INT64 = 3'h6;
  localparam logic [2:0] SEL_RSVD_A = 3'h5;
  localparam logic [2:0] SEL_RSVD_B = 3'h7;

  // Floating-point compare flag values
  localparam logic [1:0] FCMP_EQ = 2'h0;
  localparam logic [1:0] FCMP_LT = 2'h1;
  localparam logic [1:0] FCMP_GT = 2'h2;
  localparam logic [1:0] FCMP_UN = 2'h3;

  // Trap type code reported with the misc trap
  localparam logic [2:0] FTT_UNSUPPORTED = 3'h3;

  // Register map, byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_MOVES = 12'h008;
  localparam logic [11:0] ADDR_SKIPS = 12'h00C;
  localparam int CTRL_FPU_EN = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // Status fields
  localparam int ST_BUSY = 0;
  localparam int ST_PASS = 1;
  localparam int ST_OFF = 2;
  localparam int ST_MISC = 3;
  localparam int ST_FTT_LO = 4;

endpackage

// >>> design/fcm_decode.sv
// Field decoder for the conditional move instruction family.
// Assumes the instruction word is stable while it is examined; purely combinational.
`timescale 1ns/100ps
`default_nettype none
module fcm_decode
  import fcm_pkg::*;
(
  // Instruction
  input wire logic [31:0] i_instr,
  // Decoded fields
  output logic o_hit,
  output logic [3:0] o_cond,
  output logic [2:0] o_flag_set_selector,
  output logic [4:0] o_dest_reg_index,
  output logic [4:0] o_source_reg_index,
  output logic o_is_double,
  output logic o_unsupported
);

  wire logic [5:0] major_opcode = i_instr[MAJOR_HI:MAJOR_LO];
  wire logic [5:0] size_sub = i_instr[SUB_HI:SUB_LO];
  wire logic [2:0] sel = i_instr[SEL_HI:SEL_LO];
  wire logic size_ok;
  wire logic sel_rsvd;
  wire logic is_quad;

  assign size_ok = (size_sub == SUB_SINGLE) || (size_sub == SUB_DOUBLE) || is_quad;
  assign is_quad = (size_sub == SUB_QUAD);
  assign sel_rsvd = (sel == SEL_RSVD_A) || (sel == SEL_RSVD_B);
  assign o_hit = (i_instr[OP_HI:OP_LO] == FMT_ARITH) && (major_opcode == MAJOR_OPCODE_FCM)
                 && size_ok;
  assign o_cond = i_instr[COND_HI:COND_LO];
  assign o_flag_set_selector = sel;
  assign o_dest_reg_index = i_instr[RD_HI:RD_LO];
  assign o_source_reg_index = i_instr[SRC_HI:SRC_LO];
  assign o_is_double = (size_sub == SUB_DOUBLE);
  assign o_unsupported = sel_rsvd || is_quad;

endmodule
`default_nettype wire

// >>> design/fcm_cond_eval.sv
// Condition evaluator against one selected flag set.
// Assumes integer flags as n,z,v,c and compare flags as a 2-bit relation code.
`timescale 1ns/100ps
`default_nettype none
module fcm_cond_eval
  import fcm_pkg::*;
(
  // Condition and flags
  input wire logic [3:0] i_cond,
  input wire logic i_is_int,
  input wire logic [3:0] i_int_nzvc,
  input wire logic [1:0] i_fcmp,
  // Result
  output logic o_pass
);

  wire logic n = i_int_nzvc[3];
  wire logic z = i_int_nzvc[2];
  wire logic v = i_int_nzvc[1];
  wire logic c = i_int_nzvc[0];
  wire logic e = (i_fcmp == FCMP_EQ);
  wire logic l = (i_fcmp == FCMP_LT);
  wire logic g = (i_fcmp == FCMP_GT);
  wire logic u = (i_fcmp == FCMP_UN);
  wire logic [7:0] int_base;
  wire logic [7:0] fp_base;
  wire logic [7:0] base;

  // Upper half of each table is the complement of the lower half,
  // so only the lower eight tests are built.
  assign int_base = {v, n, c, c | z, n ^ v, z | (n ^ v), z, 1'b0};
  assign fp_base = {u, g, g | u, l, l | u, l | g, l | g | u, 1'b0};
  assign base = i_is_int ? int_base : fp_base;
  assign o_pass = i_cond[3] ^ base[i_cond[2:0]];

endmodule
`default_nettype wire

// >>> design/fp_cond_move_unit.sv
// Floating-point conditional move unit: decode, condition test, register copy, traps.
// Assumes the issue pipeline holds an offered instruction until o_issue_taken,
// the register file answers a read index within the same cycle, and APB control.
//
// Functional notes
// - Family recognised by major opcode 11 0101.
// - Integer conditions on Z, and on Z with N xor V, both polarities.
// - Integer unsigned conditions on C and Z, both polarities.
// - 1000 always passes, 0000 never; N and V tests both polarities.
// - Compare-flag conditions 0001 to 0111 on unordered, greater, less combinations.
// - Compare-flag conditions 1001 to 1111 include equal.
// - Selector 000-011 compare sets, 100 32-bit, 110 64-bit, 101/111 reserved.
// - Operation subfield is selector plus size subcode single, double, quad.
// - Passing condition copies source register(s) to destination register(s).
// - Failing condition writes nothing to the destination.
// - The family never changes integer or compare flags.
// - 32-bit flags follow low word, 64-bit flags follow whole result.
`timescale 1ns/100ps
`default_nettype none
module fp_cond_move_unit
  import fcm_pkg::*;
#(
  parameter int DATA_W = 64
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Issue
  input wire logic i_issue_valid,
  input wire logic [31:0] i_instr,
  output logic o_issue_ready,
  output logic o_issue_taken,
  // Flag sets
  input wire logic [3:0] i_int32_flags,
  input wire logic [3:0] i_int64_flags,
  input wire logic [1:0] i_fp_compare_flags_0,
  input wire logic [1:0] i_fp_compare_flags_1,
  input wire logic [1:0] i_fp_compare_flags_2,
  input wire logic [1:0] i_fp_compare_flags_3,
  // Register file read
  output logic [4:0] o_src_idx,
  input wire logic [DATA_W-1:0] i_src_data,
  // Register file write
  output logic o_fpr_we,
  output logic o_fpr_double,
  output logic [4:0] o_fpr_waddr,
  output logic [DATA_W-1:0] o_fpr_wdata,
  // Completion and traps
  output logic o_done,
  output logic o_fpu_off_trap,
  output logic o_fpu_misc_trap,
  output logic [2:0] o_trap_type
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_DONE = 3'b100
  } state_t;

  state_t state_r;
  state_t state_nxt;

  // Decoded fields
  logic dec_hit;
  logic [3:0] dec_cond;
  logic [2:0] dec_sel;
  logic [4:0] dec_rd;
  logic [4:0] dec_src;
  logic dec_double;
  logic dec_unsup;
  logic cond_pass;
  logic [1:0] fcmp_sel;

  fcm_decode u_decode (
    .i_instr(i_instr),
    .o_hit(dec_hit),
    .o_cond(dec_cond),
    .o_flag_set_selector(dec_sel),
    .o_dest_reg_index(dec_rd),
    .o_source_reg_index(dec_src),
    .o_is_double(dec_double),
    .o_unsupported(dec_unsup)
  );

  // Integer sets are passed through as computed by the flag unit: 32-bit
  // from the low word, 64-bit from the full result.
  wire logic [3:0] int_sel_flags = (dec_sel == SEL_INT64) ? i_int64_flags : i_int32_flags;
  wire logic sel_is_int = dec_sel[2];

  assign fcmp_sel = (dec_sel[1:0] == 2'h0) ? i_fp_compare_flags_0 :
                    (dec_sel[1:0] == 2'h1) ? i_fp_compare_flags_1 :
                    (dec_sel[1:0] == 2'h2) ? i_fp_compare_flags_2 :
                    i_fp_compare_flags_3;

  fcm_cond_eval u_cond (
    .i_cond(dec_cond),
    .i_is_int(sel_is_int),
    .i_int_nzvc(int_sel_flags),
    .i_fcmp(fcmp_sel),
    .o_pass(cond_pass)
  );

  // Control register and APB decode
  logic [31:0] ctrl_r;
  logic [31:0] moves_r;
  logic [31:0] skips_r;
  logic [31:0] status_w;
  logic [31:0] prdata_nxt;
  wire logic apb_access = i_psel && i_penable;
  wire logic hit_ctrl = (i_paddr == ADDR_CTRL);
  wire logic hit_status = (i_paddr == ADDR_STATUS);
  wire logic hit_moves = (i_paddr == ADDR_MOVES);
  wire logic hit_skips = (i_paddr == ADDR_SKIPS);
  wire logic addr_ok = hit_ctrl || hit_status || hit_moves || hit_skips;
  wire logic ctrl_wr = apb_access && i_pwrite && hit_ctrl;
  wire logic fpu_en = ctrl_r[CTRL_FPU_EN];

  // Instruction state, captured when taken
  logic pass_r;
  logic off_r;
  logic misc_r;
  logic double_r;
  logic [4:0] rd_r;
  logic [4:0] src_idx_r;

  // Last outcome for software
  logic last_pass_r;
  logic last_off_r;
  logic last_misc_r;

  assign o_issue_ready = (state_r == ST_IDLE);
  assign o_issue_taken = o_issue_ready && i_issue_valid && dec_hit;
  // A disabled unit wins over the misc trap; neither outcome writes a register.
  wire logic take_off = !fpu_en;
  wire logic take_misc = fpu_en && dec_unsup;
  wire logic exec_write = (state_r == ST_EXEC) && pass_r && !off_r && !misc_r;
  wire logic exec_skip = (state_r == ST_EXEC) && !pass_r && !off_r && !misc_r;
  wire logic exec_end = (state_r == ST_EXEC);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (o_issue_taken) begin
          state_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        state_nxt = ST_DONE;
      end
      ST_DONE: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Flags are sampled at take so a later flag update cannot change the outcome.
  // Nothing here drives any flag: the unit only reads them.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pass_r <= 1'b0;
      off_r <= 1'b0;
      misc_r <= 1'b0;
      double_r <= 1'b0;
      rd_r <= 5'h0;
      src_idx_r <= 5'h0;
    end else if (o_issue_taken) begin
      pass_r <= cond_pass;
      off_r <= take_off;
      misc_r <= take_misc;
      double_r <= dec_double;
      rd_r <= dec_rd;
      src_idx_r <= dec_src;
    end
  end

  assign o_src_idx = src_idx_r;

  // Write enable, done and trap outputs: one-cycle pulses in ST_DONE; write width, address and data hold until the next write
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fpr_we <= 1'b0;
      o_fpr_double <= 1'b0;
      o_fpr_waddr <= 5'h0;
      o_fpr_wdata <= '0;
      o_done <= 1'b0;
      o_fpu_off_trap <= 1'b0;
      o_fpu_misc_trap <= 1'b0;
      o_trap_type <= 3'h0;
    end else begin
      o_fpr_we <= exec_write;
      o_done <= exec_end;
      o_fpu_off_trap <= exec_end && off_r;
      o_fpu_misc_trap <= exec_end && misc_r;
      o_trap_type <= (exec_end && misc_r) ? FTT_UNSUPPORTED : 3'h0;
      if (exec_write) begin
        o_fpr_double <= double_r;
        o_fpr_waddr <= rd_r;
        o_fpr_wdata <= i_src_data;
      end
    end
  end

  // Control register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_r <= CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_r <= {31'h0, i_pwdata[CTRL_FPU_EN]};
    end
  end

  // Counters wrap; a write of any value to either clears it, a count in the same
  // cycle as the clear loads 1 so no completed move is lost.
  wire logic moves_clr = apb_access && i_pwrite && hit_moves;
  wire logic skips_clr = apb_access && i_pwrite && hit_skips;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      moves_r <= 32'h0000_0000;
      skips_r <= 32'h0000_0000;
    end else begin
      if (exec_write) begin
        moves_r <= moves_clr ? 32'h0000_0001 : moves_r + 32'h0000_0001;
      end else if (moves_clr) begin
        moves_r <= 32'h0000_0000;
      end
      if (exec_skip) begin
        skips_r <= skips_clr ? 32'h0000_0001 : skips_r + 32'h0000_0001;
      end else if (skips_clr) begin
        skips_r <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last_pass_r <= 1'b0;
      last_off_r <= 1'b0;
      last_misc_r <= 1'b0;
    end else if (exec_end) begin
      last_pass_r <= pass_r && !off_r && !misc_r;
      last_off_r <= off_r;
      last_misc_r <= misc_r;
    end
  end

  // Status shows the last finished instruction; only the busy bit is live.
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[ST_BUSY] = !o_issue_ready;
    status_w[ST_PASS] = last_pass_r;
    status_w[ST_OFF] = last_off_r;
    status_w[ST_MISC] = last_misc_r;
    status_w[ST_FTT_LO +: 3] = last_misc_r ? FTT_UNSUPPORTED : 3'h0;
  end

  assign prdata_nxt = hit_ctrl ? ctrl_r :
                      hit_status ? status_w :
                      hit_moves ? moves_r :
                      hit_skips ? skips_r :
                      32'h0000_0000;

  // Zero-wait slave; unmapped addresses answer with an error and zero data.
  assign o_pready = 1'b1;
  assign o_pslverr = apb_access && !addr_ok;

  // Read data is loaded in the setup cycle, so it already stands when the
  // zero-wait access phase is sampled.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      o_prdata <= prdata_nxt;
    end
  end

endmodule
`default_nettype wire

// >>> dv/fcm_regfile_model.sv
// Far-side register file read port for the conditional move unit.
// Assumes the unit reads one index and expects data back in the same cycle.
`timescale 1ns/100ps
`default_nettype none
module fcm_regfile_model #(
  parameter int DATA_W = 64
) (
  // Read index from the unit
  input wire logic [4:0] i_src_idx,
  // Read data back to the unit
  output logic [DATA_W-1:0] o_src_data
);
  // Every register holds a pattern of its own index, so a wrong index shows
  assign o_src_data = {DATA_W/8{3'h5, i_src_idx}};
endmodule
`default_nettype wire

// >>> dv/fp_cond_move_unit_properties.sv
// Port-level checks for the conditional move unit.
// Assumes one clock domain; bound into every instance of the unit.
`timescale 1ns/100ps
`default_nettype none
module fcm_checker
  import fcm_pkg::*;
#(
  parameter int DATA_W = 64
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Issue and source data
  input wire logic [31:0] i_instr,
  input wire logic o_issue_ready,
  input wire logic o_issue_taken,
  input wire logic [DATA_W-1:0] i_src_data,
  // Write and completion
  input wire logic o_fpr_we,
  input wire logic o_fpr_double,
  input wire logic [4:0] o_fpr_waddr,
  input wire logic [DATA_W-1:0] o_fpr_wdata,
  input wire logic o_done,
  input wire logic o_fpu_off_trap,
  input wire logic o_fpu_misc_trap,
  input wire logic [2:0] o_trap_type
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic [2:0] sel = i_instr[SEL_HI:SEL_LO];
  wire logic trap = o_fpu_misc_trap || o_fpu_off_trap;

  chk_family_only: assert property (o_issue_taken |-> i_instr[MAJOR_HI:MAJOR_LO] == 6'h35)
    else $error("word outside the family was taken");
  chk_answer_time: assert property (o_issue_taken |-> ##2 o_done)
    else $error("completion not two cycles after take");
  chk_busy_gap: assert property (o_issue_taken |=> !o_issue_ready [*2] ##1 o_issue_ready)
    else $error("ready gap after take wrong");
  chk_rsvd_sel: assert property (o_issue_taken && sel[2] && sel[0] |-> ##2 trap && !o_fpr_we)
    else $error("reserved selector not trapped");
  chk_quad_trap: assert property (o_issue_taken && i_instr[SUB_HI:SUB_LO] == SUB_QUAD
    |-> ##2 trap && !o_fpr_we)
    else $error("quad form not trapped");
  chk_never_move: assert property (o_issue_taken && i_instr[COND_HI:COND_LO] == 4'h0
    |-> ##2 o_done && !o_fpr_we)
    else $error("never condition wrote a register");
  chk_copy_data: assert property (o_fpr_we |-> o_fpr_wdata == $past(i_src_data)
    && o_fpr_waddr == $past(i_instr[RD_HI:RD_LO], 2))
    else $error("copy data or destination wrong");
  chk_width_flag: assert property (o_fpr_we
    |-> o_fpr_double == ($past(i_instr[SUB_HI:SUB_LO], 2) == SUB_DOUBLE))
    else $error("width flag wrong");
  chk_off_wins: assert property (o_fpu_off_trap |-> o_done && !o_fpu_misc_trap && !o_fpr_we)
    else $error("disabled trap wrong");
  chk_misc_type: assert property (o_fpu_misc_trap |-> o_done && o_trap_type == 3'h3
    && !o_fpr_we)
    else $error("misc trap type wrong");

  cover property (o_fpr_we && o_fpr_double);
  cover property (o_fpu_off_trap);
  cover property (o_fpu_misc_trap);
  cover property (o_done && !o_fpr_we && !trap);
endmodule
bind fp_cond_move_unit fcm_checker #(.DATA_W(DATA_W)) chk_u (.i_clk, .i_rst_n, .i_instr,
  .o_issue_ready, .o_issue_taken, .i_src_data, .o_fpr_we, .o_fpr_double, .o_fpr_waddr,
  .o_fpr_wdata, .o_done, .o_fpu_off_trap, .o_fpu_misc_trap, .o_trap_type);
`default_nettype wire

// >>> dv/fp_cond_move_unit_tb_top.sv
// Self-checking bench for the conditional move unit.
// Assumes the register file model answers reads in the same cycle.
`timescale 1ns/100ps
`default_nettype none
module fp_cond_move_unit_tb_top;
  import fcm_pkg::*;
  localparam int DW = 64;
  logic i_clk, i_rst_n, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, i_instr;
  logic i_issue_valid, o_issue_ready, o_issue_taken, o_fpr_we, o_fpr_double, o_done;
  logic o_fpu_off_trap, o_fpu_misc_trap;
  logic [3:0] i_int32_flags, i_int64_flags;
  logic [1:0] fc [4];
  logic [4:0] o_src_idx, o_fpr_waddr;
  logic [DW-1:0] i_src_data, o_fpr_wdata;
  logic [2:0] o_trap_type;
  int failures, tests_run;

  fp_cond_move_unit #(.DATA_W(DW)) dut_u (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_issue_valid, .i_instr,
    .o_issue_ready, .o_issue_taken, .i_int32_flags, .i_int64_flags,
    .i_fp_compare_flags_0(fc[0]), .i_fp_compare_flags_1(fc[1]), .i_fp_compare_flags_2(fc[2]),
    .i_fp_compare_flags_3(fc[3]), .o_src_idx, .i_src_data, .o_fpr_we, .o_fpr_double,
    .o_fpr_waddr, .o_fpr_wdata, .o_done, .o_fpu_off_trap, .o_fpu_misc_trap, .o_trap_type);
  fcm_regfile_model #(.DATA_W(DW)) rf_u (.i_src_idx(o_src_idx), .o_src_data(i_src_data));

  task automatic check(input bit ok, input string msg);
    tests_run++;
    if (!ok) begin
      failures++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge i_clk);
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'h1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'h1 && n < 20);
    check(o_pready === 1'h1, "bus access never answered");
    r = o_prdata;
    e = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
  endtask

  // Expected outcome worked out from flags: integer n,z,v,c or compare code k
  function automatic bit want(input logic [3:0] c, input bit is_int, input logic [3:0] f,
                              input logic [1:0] k);
    logic [7:0] iv;
    logic [31:0] fv;
    iv = {f[1], f[3], f[0], f[0] | f[2], f[3] ^ f[1], f[2] | (f[3] ^ f[1]), f[2], 1'h0};
    fv = 32'h84C2_A6E0;
    return (is_int ? iv[c[2:0]] : fv[{c[2:0], k}]) ^ c[3];
  endfunction

  // Unselected flag sets carry other values so a wrong selection shows
  task automatic issue(input logic [3:0] c, input logic [2:0] s, input logic [5:0] sz,
                       input logic [3:0] f, input logic [1:0] k);
    int n;
    @(posedge i_clk);
    i_int32_flags <= s[1] ? ~f : f;
    i_int64_flags <= s[1] ? f : ~f;
    for (int i = 0; i < 4; i++) fc[i] <= (i == int'(s[1:0])) ? k : k + 2'h1;
    i_issue_valid <= 1'h1;
    i_instr <= {FMT_ARITH, c, k[0], MAJOR_OPCODE_FCM, 1'h0, c, s, sz, f, k[1]};
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_issue_taken !== 1'h1 && n < 8);
    check(o_issue_taken === 1'h1, "family word not taken");
    i_issue_valid <= 1'h0;
    // Completion pulses stand in the cycle after the next edge only
    @(posedge i_clk);
    #1;
  endtask

  task automatic move(input logic [3:0] c, input logic [2:0] s, input logic [5:0] sz,
                      input logic [3:0] f, input logic [1:0] k);
    bit ew;
    ew = want(c, s[2], f, k);
    issue(c, s, sz, f, k);
    check(o_done === 1'h1 && o_fpu_off_trap === 1'h0 && o_fpu_misc_trap === 1'h0, "no finish");
    check(o_fpr_we === ew, "move decision wrong");
    if (ew) check(o_fpr_waddr === {c, k[0]} && o_fpr_wdata === {DW/8{3'h5, f, k[1]}}
      && o_fpr_double === (sz == SUB_DOUBLE), "copied register wrong");
  endtask

  task automatic t_regs();
    logic [31:0] r;
    logic e;
    apb(1'h0, ADDR_CTRL, 32'h0, r, e);
    check(r === CTRL_RESET && e === 1'h0, "control reset value");
    apb(1'h0, 12'h010, 32'h0, r, e);
    check(r === 32'h0 && e === 1'h1, "unmapped read");
    $display("test regs done");
  endtask

  task automatic t_int();
    for (int s = 4; s <= 6; s += 2)
      for (int c = 0; c < 16; c++)
        for (int f = 0; f < 16; f++)
          move(4'(c), 3'(s), f[0] ? SUB_DOUBLE : SUB_SINGLE, 4'(f), 2'(f));
    $display("test integer conditions done");
  endtask

  task automatic t_fp();
    for (int s = 0; s < 4; s++)
      for (int c = 0; c < 16; c++)
        for (int k = 0; k < 4; k++)
          move(4'(c), 3'(s), k[0] ? SUB_SINGLE : SUB_DOUBLE, 4'(c), 2'(k));
    $display("test compare conditions done");
  endtask

  task automatic t_traps();
    logic [31:0] r;
    logic e;
    logic [2:0] ts [3] = '{SEL_RSVD_A, SEL_RSVD_B, SEL_INT32};
    apb(1'h1, ADDR_MOVES, 32'h0, r, e);
    apb(1'h1, ADDR_SKIPS, 32'h0, r, e);
    for (int i = 0; i < 3; i++) begin
      issue(4'h8, ts[i], i == 2 ? SUB_QUAD : SUB_SINGLE, 4'h0, 2'h0);
      check(o_fpu_misc_trap === 1'h1 && o_trap_type === FTT_UNSUPPORTED && o_fpr_we === 1'h0
        && o_fpu_off_trap === 1'h0, "misc trap wrong");
    end
    apb(1'h0, ADDR_STATUS, 32'h0, r, e);
    check(r === 32'h0000_0038, "status after misc trap");
    apb(1'h1, ADDR_CTRL, 32'h0, r, e);
    for (int i = 0; i < 2; i++) begin
      issue(4'h8, 3'h4, i == 1 ? SUB_QUAD : SUB_DOUBLE, 4'h0, 2'h0);
      check(o_fpu_off_trap === 1'h1 && o_fpu_misc_trap === 1'h0 && o_fpr_we === 1'h0
        && o_done === 1'h1, "disabled trap wrong");
    end
    apb(1'h0, ADDR_STATUS, 32'h0, r, e);
    check(r === 32'h0000_0004, "status after disabled trap");
    apb(1'h1, ADDR_CTRL, CTRL_RESET, r, e);
    move(4'h8, 3'h6, SUB_DOUBLE, 4'h0, 2'h0);
    apb(1'h0, ADDR_STATUS, 32'h0, r, e);
    check(r === 32'h0000_0002, "status after move");
    move(4'h0, 3'h4, SUB_SINGLE, 4'h0, 2'h0);
    apb(1'h0, ADDR_MOVES, 32'h0, r, e);
    check(r === 32'h0000_0001, "move count wrong");
    apb(1'h0, ADDR_SKIPS, 32'h0, r, e);
    check(r === 32'h0000_0001, "no-move count wrong");
    $display("test traps done");
  endtask

  task automatic t_foreign();
    logic [31:0] w [2];
    w[0] = {FMT_ARITH, 5'h1, 6'h2C, 1'h0, 4'h8, 3'h4, SUB_SINGLE, 5'h2};
    w[1] = {FMT_ARITH, 5'h1, MAJOR_OPCODE_FCM, 1'h0, 4'h8, 3'h4, 6'h00, 5'h2};
    for (int i = 0; i < 2; i++) begin
      @(posedge i_clk);
      i_issue_valid <= 1'h1;
      i_instr <= w[i];
      repeat (3) @(posedge i_clk);
      #1 check(o_issue_taken === 1'h0 && o_fpr_we === 1'h0, "foreign word taken");
    end
    @(posedge i_clk);
    i_issue_valid <= 1'h0;
    $display("test foreign words done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    i_clk = 1'h0;
    forever #25 i_clk = ~i_clk;
  end

  initial begin
    {i_rst_n, i_psel, i_penable, i_pwrite, i_issue_valid} = 5'h00;
    {i_paddr, i_pwdata, i_instr, i_int32_flags, i_int64_flags} = 84'h0;
    for (int i = 0; i < 4; i++) fc[i] = 2'h0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'h1;
    t_regs();
    t_int();
    t_fp();
    t_traps();
    t_foreign();
    report_and_stop();
  end

  // Whole run needs about 2400 cycles
  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    report_and_stop();
  end
endmodule
`default_nettype wire
